//--- common/exec_pkg.sv
/*
 * Constants shared by the instruction execute block: opcode patterns,
 * field positions, widths and reset values.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package exec_pkg;
    localparam int          INSN_W         = 14;
    localparam int          PC_W           = 13;
    localparam int          DATA_W         = 8;
    localparam int          FADDR_W        = 7;
    localparam int          TARGET_W       = 11;
    // Call: 10 0kkk kkkk kkkk
    localparam logic [2:0]  CALL_OP        = 3'h4;
    localparam int          CALL_OP_LSB    = 11;
    // Clear file register: 00 0001 1fff ffff
    localparam logic [6:0]  CLR_FILE_OP     = 7'h03;
    localparam int          CLR_FILE_OP_LSB = 7;
    // Clear accumulator: 00 0001 0000 0011
    localparam logic [13:0] CLRACC_OP      = 14'h0103;
    // Invert file register: 00 1001 dfff ffff
    localparam logic [5:0]  INV_OP         = 6'h09;
    localparam int          INV_OP_LSB     = 8;
    localparam int          DEST_BIT       = 7;
    // Page bits of the latch feeding pc[12:11]
    localparam int          PAGE_HI        = 4;
    localparam int          PAGE_LO        = 3;
    localparam int          CALL_CYCLES    = 2;
    localparam logic [12:0] PC_RESET       = 13'h0000;
    localparam logic [7:0]  DATA_RESET     = 8'h00;
endpackage : exec_pkg

//--- src/insn_decode.sv
/*
 * Pure opcode decoder for the execute block.
 * Assumes a stable instruction word on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
module insn_decode (
    input  wire logic [13:0] insn,
    output logic             is_call,
    output logic             is_clr_file,
    output logic             is_clracc,
    output logic             is_inv
);
    // Compare the fixed opcode fields
    assign is_call   = insn[13:exec_pkg::CALL_OP_LSB] == exec_pkg::CALL_OP;
    assign is_clr_file = insn[13:exec_pkg::CLR_FILE_OP_LSB] == exec_pkg::CLR_FILE_OP;
    assign is_clracc = insn == exec_pkg::CLRACC_OP;
    assign is_inv    = insn[13:exec_pkg::INV_OP_LSB] == exec_pkg::INV_OP;
endmodule : insn_decode
`default_nettype wire

//--- src/call_clear_complement_exec.sv
/*
 * Execute stage for call, clear file register, clear accumulator and
 * invert file register. Holds pc, accumulator and zero flag.
 * Assumes the fetch side presents insn with insn_valid and that the file
 * register read data for file_addr returns combinationally in file_rdata.
 */
// Overview of operation
// [RQ1] Call pushes pc plus one onto stack
// [RQ2] Call loads 11-bit target into pc[10:0]
// [RQ3] Call takes pc[12:11] from page latch bits
// [RQ4] Call takes two cycles, flags untouched
// [RQ5] Clear file register writes zero, sets zero
// [RQ6] Invert file register, zero flag from result
// [RQ7] Destination bit picks accumulator or file
// [RQ8] Clear accumulator zeroes it, sets zero flag
`timescale 1ns/100ps
`default_nettype none
module call_clear_complement_exec (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [13:0] insn,
    input  wire logic        insn_valid,
    input  wire logic [7:0]  page_select_latch,
    input  wire logic [7:0]  file_rdata,
    output logic [12:0]      pc,
    output logic             insn_ready,
    output logic             stack_push,
    output logic [12:0]      stack_head,
    output logic             file_we,
    output logic [6:0]       file_addr,
    output logic [7:0]       file_wdata,
    output logic [7:0]       accumulator,
    output logic             zero_flag
);
    // One-hot states; CALL_SLOT2 is the refused second call cycle
    typedef enum logic [1:0] {
        EXECUTE    = 2'b01,
        CALL_SLOT2 = 2'b10
    } exec_state_e;

    // State register, decoded strobes and operand wires
    exec_state_e state;
    exec_state_e next_state;
    logic        is_call;
    logic        is_clr_file;
    logic        is_clracc;
    logic        is_inv;
    wire         take;
    wire  [7:0]  inv_result;
    wire         dest_file;
    wire  [12:0] call_target;
    wire  [12:0] pc_plus_one;

    insn_decode u_decode (
        .insn        (insn),
        .is_call     (is_call),
        .is_clr_file (is_clr_file),
        .is_clracc   (is_clracc),
        .is_inv      (is_inv)
    );

    // Refuse package values that the fixed port widths or the two-cycle call state machine cannot carry
    if (exec_pkg::INSN_W != 14 || exec_pkg::PC_W != 13 || exec_pkg::DATA_W != 8) begin : g_bad_width
        $error("execute block serves only 14-bit insn, 13-bit pc and 8-bit data");
    end
    if (exec_pkg::TARGET_W + exec_pkg::PAGE_HI - exec_pkg::PAGE_LO + 1 != exec_pkg::PC_W) begin : g_bad_page
        $error("call target and page bits do not fill the pc");
    end
    if (exec_pkg::CALL_CYCLES != 2 || exec_pkg::FADDR_W != 7) begin : g_bad_count
        $error("state machine serves a two-cycle call and 7-bit file address only");
    end

    // Issue and operand wiring
    assign take        = insn_valid && (state == EXECUTE);
    assign inv_result  = ~file_rdata;                                  // [RQ6]
    assign dest_file   = insn[exec_pkg::DEST_BIT];                     // [RQ7]
    assign pc_plus_one = pc + 13'h0001;                                // [RQ1]
    assign call_target = {page_select_latch[exec_pkg::PAGE_HI:exec_pkg::PAGE_LO],
                          insn[exec_pkg::TARGET_W-1:0]};               // [RQ2] [RQ3]
    // Read address follows insn so the read returns in the issue cycle
    assign file_addr   = insn[exec_pkg::FADDR_W-1:0];

    // Call holds a second cycle; everything else is single cycle
    always_comb begin
        case (state)
            EXECUTE:    next_state = (take && is_call) ? CALL_SLOT2 : EXECUTE; // [RQ4]
            CALL_SLOT2: next_state = EXECUTE;
            default:    next_state = EXECUTE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= EXECUTE;
        end else begin
            state <= next_state;
        end
    end

    // Program counter and return stack
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pc         <= exec_pkg::PC_RESET;
            stack_push <= 1'b0;
            stack_head <= exec_pkg::PC_RESET;
            insn_ready <= 1'b0;
        end else begin
            stack_push <= take && is_call;                             // [RQ1]
            insn_ready <= !(take && is_call);                          // [RQ4]
            if (take && is_call) begin
                stack_head <= pc_plus_one;                             // [RQ1]
                pc         <= call_target;                             // [RQ2] [RQ3]
            end else if (take) begin
                pc <= pc_plus_one;
            end
        end
    end

    // File write port
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            file_we    <= 1'b0;
            file_wdata <= exec_pkg::DATA_RESET;
        end else begin
            file_we    <= take && (is_clr_file || (is_inv && dest_file)); // [RQ5] [RQ7]
            file_wdata <= is_clr_file ? exec_pkg::DATA_RESET : inv_result; // [RQ5] [RQ6]
        end
    end

    // Accumulator and zero flag; call leaves flags alone
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            accumulator <= exec_pkg::DATA_RESET;
            zero_flag   <= 1'b0;
        end else if (take) begin
            if (is_clracc) begin
                accumulator <= exec_pkg::DATA_RESET;                   // [RQ8]
                zero_flag   <= 1'b1;
            end else if (is_clr_file) begin
                zero_flag <= 1'b1;                                     // [RQ5]
            end else if (is_inv) begin
                zero_flag <= (inv_result == exec_pkg::DATA_RESET);     // [RQ6]
                if (!dest_file) begin
                    accumulator <= inv_result;                         // [RQ7]
                end
            end
        end
    end

    // Named steps of each instruction
    sequence s_call_issue;
        take && is_call;
    endsequence
    sequence s_call_slot;
        state == CALL_SLOT2;
    endsequence
    sequence s_clr_file_issue;
        take && is_clr_file;
    endsequence
    sequence s_clracc_issue;
        take && is_clracc;
    endsequence
    sequence s_inv_issue;
        take && is_inv;
    endsequence

    // Call: push, target, page bits and the refused second cycle
    a_call_push: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ1]
        s_call_issue |=> stack_push && stack_head == $past(pc) + 13'h0001)
        else $error("call did not push return address");
    a_call_target: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ2]
        s_call_issue |=> pc[exec_pkg::TARGET_W-1:0] == $past(insn[exec_pkg::TARGET_W-1:0]))
        else $error("call target low bits wrong");
    a_call_page: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ3]
        s_call_issue |=> pc[exec_pkg::PC_W-1:exec_pkg::TARGET_W] ==
            $past(page_select_latch[exec_pkg::PAGE_HI:exec_pkg::PAGE_LO]))
        else $error("call page bits wrong");
    a_call_two_cycles: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        s_call_issue |=> state == CALL_SLOT2 && $stable(zero_flag) ##1 state == EXECUTE)
        else $error("call not two cycles or flag altered");
    a_call_quiet: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        s_call_issue |=> !file_we && $stable(accumulator))
        else $error("call touched file or accumulator");
    a_ready_after_call: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        s_call_issue |=> !insn_ready ##1 insn_ready)
        else $error("ready not low for exactly the second call cycle");
    a_slot_refuse: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        s_call_slot |=> $stable(pc) && !stack_push && !file_we && insn_ready)
        else $error("second call cycle accepted an instruction");
    a_push_once: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ1]
        stack_push |=> !stack_push)
        else $error("stack push longer than one cycle");

    // File register and accumulator results
    a_clr_file_write: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ5]
        s_clr_file_issue |=> file_we && file_wdata == 8'h00 && zero_flag)
        else $error("clear file register failed");
    a_clr_file_keep: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ5]
        s_clr_file_issue |=> $stable(accumulator) && !stack_push)
        else $error("clear file register touched accumulator");
    a_inv_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ6]
        s_inv_issue |=> zero_flag == ($past(file_rdata) == 8'hff))
        else $error("invert zero flag wrong");
    a_inv_dest: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ7]
        s_inv_issue ##0 !dest_file |=> !file_we && accumulator == ~$past(file_rdata))
        else $error("invert destination wrong");
    a_inv_write: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ7]
        s_inv_issue ##0 dest_file |=> file_we && file_wdata == ~$past(file_rdata))
        else $error("invert write back wrong");
    a_inv_acc_keep: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ7]
        s_inv_issue ##0 dest_file |=> $stable(accumulator))
        else $error("invert to file changed accumulator");
    a_clracc_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ8]
        s_clracc_issue |=> accumulator == 8'h00 && zero_flag && !file_we)
        else $error("clear accumulator failed");

    // State, strobes and idle cycles
    a_state_onehot: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        $onehot(state))
        else $error("execute state not one-hot");
    a_strobe_idle: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ1]
        !take |=> !stack_push && !file_we)
        else $error("strobe without a taken instruction");
    a_flag_idle: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        !take |=> $stable(zero_flag) && $stable(accumulator))
        else $error("flag or accumulator changed while idle");
    a_pc_advance: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ4]
        take && !is_call |=> pc == $past(pc) + 13'h0001)
        else $error("single-word instruction did not step pc");
endmodule : call_clear_complement_exec
`default_nettype wire

//--- verification/exec_partner.sv
/* Far-side model: data register file with combinational read, plus a
   return stack. Assumes the write lands at the address shown the cycle before. */
`timescale 1ns/100ps
`default_nettype none
module exec_partner (
    input  wire logic        core_clk,
    input  wire logic [6:0]  file_addr,
    input  wire logic        file_we,
    input  wire logic [7:0]  file_wdata,
    input  wire logic        stack_push,
    input  wire logic [12:0] stack_head,
    output logic      [7:0]  file_rdata
);
    logic [7:0]  mem [128];
    logic [6:0]  addr_q;
    logic [12:0] stack [$];
    logic [12:0] last_push = '0; // Newest stack entry, read by the bench
    // Same fill as the bench model
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
    assign file_rdata = mem[file_addr];
    // Address is held over from the issue cycle, since file_addr follows insn
    always @(posedge core_clk) begin
        addr_q <= file_addr;
        if (file_we) mem[addr_q] <= file_wdata;
        if (stack_push) stack.push_back(stack_head);
        if (stack_push) last_push <= stack_head;
    end
endmodule : exec_partner
`default_nettype wire

//--- verification/tb.sv
/* Random instruction mix against a behavioural model.
   Assumes the partner holds the file memory and return stack. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        core_clk = 0, reset_n = 0, insn_valid = 0;
    logic [13:0] insn = '0;
    logic [7:0]  page_select_latch = '0, file_rdata, file_wdata, accumulator;
    logic [12:0] pc, stack_head;
    logic [6:0]  file_addr;
    logic        insn_ready, stack_push, file_we, zero_flag;
    logic [31:0] s = 32'hce70bf24;
    int          n_errors = 0, n_checks = 0;
    int          m_pc = 0, m_acc = 0, m_z = 0, m_head = 0, m_wd, m_mem[128];
    always #10 core_clk = ~core_clk;
    call_clear_complement_exec i_call_clear_complement_exec (.core_clk(core_clk), .reset_n(reset_n),
        .insn(insn), .insn_valid(insn_valid), .page_select_latch(page_select_latch),
        .file_rdata(file_rdata), .pc(pc), .insn_ready(insn_ready), .stack_push(stack_push),
        .stack_head(stack_head), .file_we(file_we), .file_addr(file_addr),
        .file_wdata(file_wdata), .accumulator(accumulator), .zero_flag(zero_flag));
    exec_partner i_exec_partner (.core_clk(core_clk), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .stack_push(stack_push), .stack_head(stack_head),
        .file_rdata(file_rdata));
    // Random source
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // Compare a multi-bit value
    task automatic chk_word(input string name, input int exp, input logic [12:0] got);
        n_checks++;
        if (got !== 13'(exp)) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask : chk_word
    // Compare a single flag
    task automatic chk_flag(input string name, input int exp, input logic got);
        n_checks++;
        if (got !== 1'(exp)) begin
            n_errors++;
            $display("unexpected %s: expected %0d seen %b", name, exp, got);
        end
    endtask : chk_flag
    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // Reset, then random calls, clears and inverts, each checked
    initial begin
        int f, kind;
        for (int i = 0; i < 128; i++) m_mem[i] = (i * 37 + 5) & 8'hff;
        repeat (6) @(negedge core_clk);
        reset_n = 1;
        for (int w = 0; w < 20 && insn_ready !== 1'b1; w++) @(negedge core_clk);
        if (insn_ready !== 1'b1) begin
            n_errors++;
            final_report();
        end
        for (int t = 0; t < 200; t++) begin
            s = lfsr(s);
            kind = s[1:0];
            f = s[8:2];
            page_select_latch = s[31:24];
            case (kind)
                0: insn = {exec_pkg::CALL_OP, s[20:10]};
                1: insn = {exec_pkg::CLR_FILE_OP, s[8:2]};
                2: insn = exec_pkg::CLRACC_OP;
                default: insn = {exec_pkg::INV_OP, s[9], s[8:2]};
            endcase
            insn_valid = 1;
            m_wd = -1;
            case (kind)
                0: begin
                    m_head = (m_pc + 1) & 13'h1fff;
                    m_pc = {s[28:27], s[20:10]};
                end
                1: m_wd = 0;
                2: m_acc = 0;
                default: begin
                    m_wd = ~m_mem[f] & 8'hff;
                    if (!s[9]) m_acc = m_wd;
                end
            endcase
            if (kind == 2) m_z = 1;
            if (kind == 3) m_z = (m_wd == 0);
            if (kind == 1) m_z = 1;
            if (kind == 3 && !s[9]) m_wd = -1;
            if (kind != 0) m_pc = (m_pc + 1) & 13'h1fff;
            if (m_wd >= 0) m_mem[f] = m_wd;
            @(negedge core_clk);
            insn_valid = (kind == 0); // Repeated call offer must be ignored
            chk_word("pc", m_pc, pc);
            chk_word("accumulator", m_acc, 13'(accumulator));
            chk_flag("zero_flag", m_z, zero_flag);
            chk_flag("stack_push", kind == 0, stack_push);
            chk_flag("insn_ready", kind != 0, insn_ready);
            chk_flag("file_we", m_wd >= 0, file_we);
            if (kind == 0) chk_word("stack_head", m_head, stack_head);
            if (m_wd >= 0) chk_word("file_wdata", m_wd, 13'(file_wdata));
            if (kind == 1 || kind == 3) chk_word("file_addr", f, 13'(file_addr));
            @(negedge core_clk);
            chk_word("pc", m_pc, pc);
            chk_flag("zero_flag", m_z, zero_flag);
            chk_word("accumulator", m_acc, 13'(accumulator));
            chk_flag("stack_push", 0, stack_push);
            chk_flag("file_we", 0, file_we);
            chk_word("stack_top", m_head, i_exec_partner.last_push);
            chk_word("file_mem", m_mem[f], 13'(i_exec_partner.mem[f]));
            chk_flag("insn_ready", 1, insn_ready);
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
